// *** rtl/ctc_consts.vh ***
// Constants for the calibration trigger control block: register indices,
// field positions, reset values and the low-power delay tables.
// Assumes inclusion by bare name from rtl/ design files and tb/ bench files.
`ifndef CTC_CONSTS_VH
`define CTC_CONSTS_VH

// ============================================================
// Register indices (byte address is four times the index)
`define CTC_IDX_CAL_STATUS    10'h06A
`define CTC_IDX_PIN_CFG       10'h06B
`define CTC_IDX_SOFT_TRIG     10'h06C
`define CTC_IDX_LP_CFG        10'h06E
`define CTC_IDX_BG_CTRL       10'h070
`define CTC_IDX_IRQ_STATUS    10'h071
`define CTC_IDX_IRQ_ENABLE    10'h072
`define CTC_IDX_IRQ_CLEAR     10'h073
`define CTC_IDX_LP_STATE      10'h074

// ============================================================
// Field positions
`define CTC_PIN_TRIG_SRC      0
`define CTC_PIN_STAT_LO       1
`define CTC_PIN_STAT_HI       2
`define CTC_SOFT_TRIG_BIT     0
`define CTC_LOW_POWER_ENABLE_BIT         0
`define CTC_TRIGGERED_SLEEP_MODE_BIT       1
`define CTC_LP_WAKE_LO        3
`define CTC_LP_WAKE_HI        4
`define CTC_LP_SLEEP_LO       5
`define CTC_LP_SLEEP_HI       7
`define CTC_BG_EN_BIT         0
`define CTC_IRQ_W             4

// ============================================================
// Status select codes
`define CTC_STAT_FOREGROUND_DONE_FLAG      2'h0
`define CTC_STAT_STOPPED      2'h1
`define CTC_STAT_ALARM        2'h2
`define CTC_STAT_LOW          2'h3

// ============================================================
// Reset values
`define CTC_RST_PIN_CFG       8'h00
`define CTC_RST_SOFT_TRIG     8'h01
`define CTC_RST_LP_CFG        8'h88
`define CTC_RST_BG_CTRL       8'h00

// ============================================================
// Delay tables, figures in device clock periods (tCLK)
`define CTC_CNT_W             41
`define CTC_CLK_PER_TCLK      41'h001
`define CTC_SLEEP_TCLK0       41'd1152
`define CTC_SLEEP_TCLK1       41'd1152
`define CTC_SLEEP_TCLK2       41'd4194432
`define CTC_SLEEP_TCLK3       41'd268435584
`define CTC_SLEEP_TCLK4       41'd2147483776
`define CTC_SLEEP_TCLK5       41'd137438953600
`define CTC_SLEEP_TCLK6       41'd137438953600
`define CTC_SLEEP_TCLK7       41'd1099511627904
`define CTC_WAKE_TCLK0        41'd1152
`define CTC_WAKE_TCLK1        41'd33554560
`define CTC_WAKE_TCLK2        41'd268435584
`define CTC_WAKE_TCLK3        41'd2147483776
`define CTC_CYC(t)            ((t) * `CTC_CLK_PER_TCLK)
`define CTC_SLEEP_TABLE       {`CTC_CYC(`CTC_SLEEP_TCLK7), `CTC_CYC(`CTC_SLEEP_TCLK6), `CTC_CYC(`CTC_SLEEP_TCLK5), \
                               `CTC_CYC(`CTC_SLEEP_TCLK4), `CTC_CYC(`CTC_SLEEP_TCLK3), `CTC_CYC(`CTC_SLEEP_TCLK2), \
                               `CTC_CYC(`CTC_SLEEP_TCLK1), `CTC_CYC(`CTC_SLEEP_TCLK0)}
`define CTC_WAKE_TABLE        {`CTC_CYC(`CTC_WAKE_TCLK3), `CTC_CYC(`CTC_WAKE_TCLK2), \
                               `CTC_CYC(`CTC_WAKE_TCLK1), `CTC_CYC(`CTC_WAKE_TCLK0)}

`endif

// *** rtl/ctc_status_mux.v ***
// Status pin source selector, purely combinational.
// Assumes the caller registers the result before it reaches a pin.
`timescale 1ns/1ps
`default_nettype none
`include "ctc_consts.vh"

module ctc_status_mux
(
  // Selection
  input  wire [1:0] status_sel,
  // Candidate sources
  input  wire       foreground_done_flag,
  input  wire       calibration_stopped_flag,
  input  wire       alarm_flag,
  // Result
  output reg        status_value
);

  // ============================================================
  // Source selection
  always @*
  begin
    case (status_sel)
      // (RL1) foreground done
      `CTC_STAT_FOREGROUND_DONE_FLAG: status_value = foreground_done_flag;
      // (RL2) calibration stopped
      `CTC_STAT_STOPPED: status_value = calibration_stopped_flag;
      // (RL3) alarm indication
      `CTC_STAT_ALARM:   status_value = alarm_flag;
      // (RL4) constant low
      default:           status_value = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// *** rtl/ctc_lp_seq.v ***
// Low-power background calibration sequencer: sleep, settle, calibrate.
// Assumes delay counts arrive already selected and stable while counting.
`timescale 1ns/1ps
`default_nettype none
`include "ctc_consts.vh"

module ctc_lp_seq #(
  parameter CNT_W = `CTC_CNT_W
)(
  // Clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // Control
  input  wire             active,
  input  wire             trig_mode,
  input  wire             trigger,
  input  wire [CNT_W-1:0] sleep_cycles,
  input  wire [CNT_W-1:0] wake_cycles,
  input  wire             cal_cycle_done,
  // Results
  output reg              adc_sleep,
  output reg              cal_request,
  output reg              wake_pulse,
  output reg  [1:0]       state
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_SLEEP = 2'h1;
  localparam [1:0] ST_WAKE  = 2'h2;
  localparam [1:0] ST_CALIB = 2'h3;

  reg [CNT_W-1:0] cnt;
  reg [1:0]       next_state;
  wire            sleep_over;
  wire            wake_over;

  // (RL13) trigger or timer ends sleep
  assign sleep_over = trig_mode ? ~trigger : (cnt + {{(CNT_W-1){1'b0}}, 1'b1} >= sleep_cycles);
  assign wake_over  = (cnt + {{(CNT_W-1){1'b0}}, 1'b1} >= wake_cycles);

  // ============================================================
  // Next state
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:  if (active) next_state = ST_SLEEP;
      ST_SLEEP: if (sleep_over) next_state = ST_WAKE;
      ST_WAKE:  if (wake_over) next_state = ST_CALIB;
      default:  if (cal_cycle_done) next_state = ST_SLEEP;
    endcase
    // (RL14) inactive unless enabled
    if (!active)
      next_state = ST_IDLE;
  end

  // ============================================================
  // State, counter and outputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state       <= ST_IDLE;
      cnt         <= {CNT_W{1'b0}};
      adc_sleep   <= 1'b0;
      cal_request <= 1'b0;
      wake_pulse  <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      cnt         <= (next_state != state) ? {CNT_W{1'b0}} : cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      adc_sleep   <= (next_state == ST_SLEEP);
      cal_request <= (next_state == ST_CALIB);
      wake_pulse  <= (next_state == ST_CALIB) && (state == ST_WAKE);
    end
  end

endmodule
`default_nettype wire

// *** rtl/ctc_top.v ***
// Calibration trigger and status pin control with low-power calibration
// settings, reached over APB. Assumes the calibration engine outside drives
// the done, stopped and alarm flags synchronously to pclk.
//
// How it works
// (RL1) Select 0 routes foreground done to pin
// (RL2) Select 1 routes calibration stopped to pin
// (RL3) Select 2 routes alarm to pin
// (RL4) Select 3 holds status pin low
// (RL5) Source 0 uses software bit, pin ignored
// (RL6) Source 1 uses trigger pin, bit ignored
// (RL7) Software bit 0 resets high, acts as pin
// (RL8) Software writes reserved bits as zero
// (RL9) Pin configuration resets to zero
// (RL10) Software trigger register resets to one
// (RL11) Low-power register resets 0x88 with fields
// (RL12) Keep source at software when unused
// (RL13) Triggered mode: low wakes, high sleeps
// (RL14) Low-power acts only with background enabled
// (RL15) Stopped flag follows halt and resume
// (RL16) Foreground done flag high after completion
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "ctc_consts.vh"

module ctc_top #(
  parameter                        CNT_W        = `CTC_CNT_W,
  parameter [8*`CTC_CNT_W-1:0]     SLEEP_CYCLES = `CTC_SLEEP_TABLE,
  parameter [4*`CTC_CNT_W-1:0]     WAKE_CYCLES  = `CTC_WAKE_TABLE
)(
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Calibration engine side
  input  wire        foreground_done_flag,
  input  wire        calibration_stopped_flag,
  input  wire        alarm_flag,
  input  wire        cal_cycle_done,
  output reg         calibration_trigger,
  output reg         adc_sleep,
  output reg         cal_request,
  // Pins
  input  wire        calibration_trigger_pin,
  output reg         calibration_status_pin,
  // Interrupt
  output reg         irq
);

  // ============================================================
  // Address decoding
  function idx_hit;
    input [11:0] addr;
    input [9:0]  idx;
    begin
      idx_hit = (addr[11:2] == idx) && (addr[1:0] == 2'h0);
    end
  endfunction

  // ============================================================
  // Register state
  localparam [7:0] RST_PIN  = `CTC_RST_PIN_CFG;
  localparam [7:0] RST_SOFT = `CTC_RST_SOFT_TRIG;
  localparam [7:0] RST_LP   = `CTC_RST_LP_CFG;
  localparam [7:0] RST_BG   = `CTC_RST_BG_CTRL;
  reg        trigger_source_select;
  reg [1:0]  status_sel;
  reg        software_trigger_bit;
  reg [2:0]  sleep_delay_field;
  reg [1:0]  wake_delay_field;
  reg        triggered_sleep_mode;
  reg        low_power_enable;
  reg        background_calibration_enable;
  reg [`CTC_IRQ_W-1:0] irq_status;
  reg [`CTC_IRQ_W-1:0] irq_enable;

  // Previous flag levels for edge events
  reg        foreground_done_flag_d;
  reg        stopped_d;
  reg        alarm_d;

  wire       setup_phase;
  wire       write_take;
  reg [31:0] next_prdata;
  reg        next_hit;
  wire       status_value;
  wire       seq_sleep;
  wire       seq_request;
  wire       seq_wake_pulse;
  wire [1:0] seq_state;
  wire       lp_active;
  wire       selected_trigger;
  wire [CNT_W-1:0] sleep_cycles;
  wire [CNT_W-1:0] wake_cycles;
  wire [`CTC_IRQ_W-1:0] irq_events;
  wire [`CTC_IRQ_W-1:0] irq_clear;

  assign setup_phase = psel & ~penable;
  assign write_take  = psel & penable & pready & pwrite & ~pslverr;

  // ============================================================
  // Trigger source
  // (RL5) software bit when source is 0
  // (RL6) trigger pin when source is 1
  assign selected_trigger = trigger_source_select ? calibration_trigger_pin : software_trigger_bit;

  // (RL14) gated by background enable
  assign lp_active = low_power_enable & background_calibration_enable;

  assign sleep_cycles = SLEEP_CYCLES[sleep_delay_field*CNT_W +: CNT_W];
  assign wake_cycles  = WAKE_CYCLES[wake_delay_field*CNT_W +: CNT_W];

  // ============================================================
  // Submodules
  ctc_status_mux u_status_mux
  (
    .status_sel               (status_sel),
    .foreground_done_flag     (foreground_done_flag),
    .calibration_stopped_flag (calibration_stopped_flag),
    .alarm_flag               (alarm_flag),
    .status_value             (status_value)
  );

  ctc_lp_seq #(
    .CNT_W (CNT_W)
  ) u_lp_seq (
    .pclk           (pclk),
    .presetn        (presetn),
    .active         (lp_active),
    .trig_mode      (triggered_sleep_mode),
    .trigger        (selected_trigger),
    .sleep_cycles   (sleep_cycles),
    .wake_cycles    (wake_cycles),
    .cal_cycle_done (cal_cycle_done),
    .adc_sleep      (seq_sleep),
    .cal_request    (seq_request),
    .wake_pulse     (seq_wake_pulse),
    .state          (seq_state)
  );

  // ============================================================
  // Read data and address check
  always @*
  begin
    next_prdata = 32'h0000_0000;
    next_hit    = 1'b1;
    if (idx_hit(paddr, `CTC_IDX_CAL_STATUS))
    begin
      // (RL15) stopped flag bit 1
      next_prdata[1] = calibration_stopped_flag;
      // (RL16) foreground done bit 0
      next_prdata[0] = foreground_done_flag;
    end
    else if (idx_hit(paddr, `CTC_IDX_PIN_CFG))
    begin
      next_prdata[`CTC_PIN_STAT_HI:`CTC_PIN_STAT_LO] = status_sel;
      next_prdata[`CTC_PIN_TRIG_SRC]                 = trigger_source_select;
    end
    else if (idx_hit(paddr, `CTC_IDX_SOFT_TRIG))
      next_prdata[`CTC_SOFT_TRIG_BIT] = software_trigger_bit;
    else if (idx_hit(paddr, `CTC_IDX_LP_CFG))
    begin
      next_prdata[`CTC_LP_SLEEP_HI:`CTC_LP_SLEEP_LO] = sleep_delay_field;
      next_prdata[`CTC_LP_WAKE_HI:`CTC_LP_WAKE_LO]   = wake_delay_field;
      next_prdata[`CTC_TRIGGERED_SLEEP_MODE_BIT]                  = triggered_sleep_mode;
      next_prdata[`CTC_LOW_POWER_ENABLE_BIT]                    = low_power_enable;
    end
    else if (idx_hit(paddr, `CTC_IDX_BG_CTRL))
      next_prdata[`CTC_BG_EN_BIT] = background_calibration_enable;
    else if (idx_hit(paddr, `CTC_IDX_IRQ_STATUS))
      next_prdata[`CTC_IRQ_W-1:0] = irq_status;
    else if (idx_hit(paddr, `CTC_IDX_IRQ_ENABLE))
      next_prdata[`CTC_IRQ_W-1:0] = irq_enable;
    else if (idx_hit(paddr, `CTC_IDX_IRQ_CLEAR))
      next_prdata = 32'h0000_0000;
    else if (idx_hit(paddr, `CTC_IDX_LP_STATE))
    begin
      next_prdata[3:2] = seq_state;
      next_prdata[1]   = seq_request;
      next_prdata[0]   = seq_sleep;
    end
    else
      next_hit = 1'b0;
  end

  // ============================================================
  // APB handshake: one wait-free access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~next_hit;
      if (setup_phase && !pwrite)
        prdata <= next_hit ? next_prdata : 32'h0000_0000;
    end
  end

  // ============================================================
  // Configuration registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // (RL9) pin configuration reset
      trigger_source_select         <= RST_PIN[`CTC_PIN_TRIG_SRC];
      status_sel                    <= RST_PIN[`CTC_PIN_STAT_HI:`CTC_PIN_STAT_LO];
      // (RL10) software trigger reset
      software_trigger_bit          <= RST_SOFT[`CTC_SOFT_TRIG_BIT];
      // (RL11) low-power reset fields
      sleep_delay_field             <= RST_LP[`CTC_LP_SLEEP_HI:`CTC_LP_SLEEP_LO];
      wake_delay_field              <= RST_LP[`CTC_LP_WAKE_HI:`CTC_LP_WAKE_LO];
      triggered_sleep_mode          <= RST_LP[`CTC_TRIGGERED_SLEEP_MODE_BIT];
      low_power_enable              <= RST_LP[`CTC_LOW_POWER_ENABLE_BIT];
      background_calibration_enable <= RST_BG[`CTC_BG_EN_BIT];
      irq_enable                    <= {`CTC_IRQ_W{1'b0}};
    end
    else if (write_take)
    begin
      if (idx_hit(paddr, `CTC_IDX_PIN_CFG))
      begin
        trigger_source_select <= pwdata[`CTC_PIN_TRIG_SRC];
        status_sel            <= pwdata[`CTC_PIN_STAT_HI:`CTC_PIN_STAT_LO];
      end
      else if (idx_hit(paddr, `CTC_IDX_SOFT_TRIG))
        // (RL7) software trigger level
        software_trigger_bit <= pwdata[`CTC_SOFT_TRIG_BIT];
      else if (idx_hit(paddr, `CTC_IDX_LP_CFG))
      begin
        // (RL11) low-power field layout
        sleep_delay_field    <= pwdata[`CTC_LP_SLEEP_HI:`CTC_LP_SLEEP_LO];
        wake_delay_field     <= pwdata[`CTC_LP_WAKE_HI:`CTC_LP_WAKE_LO];
        triggered_sleep_mode <= pwdata[`CTC_TRIGGERED_SLEEP_MODE_BIT];
        low_power_enable     <= pwdata[`CTC_LOW_POWER_ENABLE_BIT];
      end
      else if (idx_hit(paddr, `CTC_IDX_BG_CTRL))
        background_calibration_enable <= pwdata[`CTC_BG_EN_BIT];
      else if (idx_hit(paddr, `CTC_IDX_IRQ_ENABLE))
        irq_enable <= pwdata[`CTC_IRQ_W-1:0];
    end
  end

  // ============================================================
  // Interrupt events: rising flags and low-power wake
  assign irq_events = {seq_wake_pulse, alarm_flag & ~alarm_d,
    calibration_stopped_flag & ~stopped_d, foreground_done_flag & ~foreground_done_flag_d};
  assign irq_clear  = (write_take && idx_hit(paddr, `CTC_IDX_IRQ_CLEAR)) ? pwdata[`CTC_IRQ_W-1:0] : {`CTC_IRQ_W{1'b0}};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      foreground_done_flag_d  <= 1'b0;
      stopped_d  <= 1'b0;
      alarm_d    <= 1'b0;
      irq_status <= {`CTC_IRQ_W{1'b0}};
      irq        <= 1'b0;
    end
    else
    begin
      foreground_done_flag_d  <= foreground_done_flag;
      stopped_d  <= calibration_stopped_flag;
      alarm_d    <= alarm_flag;
      // Set wins over a clear in the same cycle
      irq_status <= (irq_status & ~irq_clear) | irq_events;
      irq        <= |(((irq_status & ~irq_clear) | irq_events) & irq_enable);
    end
  end

  // ============================================================
  // Registered pin and engine outputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      calibration_status_pin <= 1'b0;
      calibration_trigger    <= 1'b0;
      adc_sleep              <= 1'b0;
      cal_request            <= 1'b0;
    end
    else
    begin
      // (RL4) mux output registered
      calibration_status_pin <= status_value;
      // (RL6) selected trigger out
      calibration_trigger    <= selected_trigger;
      // (RL13) sleep while sequencer sleeps
      adc_sleep              <= seq_sleep;
      cal_request            <= seq_request;
    end
  end

endmodule
`default_nettype wire

// *** tb/ctc_engine_model.sv ***
// Calibration engine and external trigger controller stand-in.
// Assumes commands change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module ctc_engine_model #(
  parameter int STEP_WAIT = 4
)(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Commands from the bench
  input  wire logic [2:0] flag_cmd,
  input  wire logic       trig_cmd,
  input  wire logic       cal_request,
  // Engine flags and trigger pin
  output var  logic       foreground_done_flag,
  output var  logic       calibration_stopped_flag,
  output var  logic       alarm_flag,
  output var  logic       cal_cycle_done,
  output var  logic       calibration_trigger_pin
);
  logic [7:0] wait_cnt;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {alarm_flag, calibration_stopped_flag, foreground_done_flag} <= 3'h0;
      calibration_trigger_pin <= 1'b0;
      cal_cycle_done <= 1'b0;
      wait_cnt <= 8'h00;
    end
    else
    begin
      {alarm_flag, calibration_stopped_flag, foreground_done_flag} <= flag_cmd;
      calibration_trigger_pin <= trig_cmd;
      cal_cycle_done <= cal_request && (wait_cnt == STEP_WAIT[7:0]);
      wait_cnt <= (!cal_request || wait_cnt == STEP_WAIT[7:0]) ? 8'h00 : wait_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** tb/ctc_top_asserts.sv ***
// Port checker for the calibration trigger control block.
// Assumes shadows follow completed APB writes.
`timescale 1ns/1ps
`default_nettype none
`include "ctc_consts.vh"

module ctc_top_asserts (
  // Clock, reset and APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Flags and pins
  input wire logic        foreground_done_flag,
  input wire logic        calibration_stopped_flag,
  input wire logic        alarm_flag,
  input wire logic        calibration_trigger,
  input wire logic        adc_sleep,
  input wire logic        cal_request,
  input wire logic        calibration_status_pin,
  input wire logic        calibration_trigger_pin,
  input wire logic        irq
);
  // ============================================================
  // Shadows of written registers
  logic [2:0] sh_cfg;
  logic       sh_soft;
  logic [3:0] sh_en;
  logic       sh_bg;
  logic [1:0] live;
  wire        wr = psel && penable && pready && pwrite && !pslverr;
  wire [9:0]  idx = paddr[11:2];
  wire        mapped = paddr[1:0] == 2'h0 && idx inside {`CTC_IDX_CAL_STATUS, `CTC_IDX_PIN_CFG,
    `CTC_IDX_SOFT_TRIG, `CTC_IDX_LP_CFG, `CTC_IDX_BG_CTRL, `CTC_IDX_IRQ_STATUS,
    `CTC_IDX_IRQ_ENABLE, `CTC_IDX_IRQ_CLEAR, `CTC_IDX_LP_STATE};
  wire        ok = live == 2'h3;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {sh_cfg, sh_soft, sh_en, sh_bg, live} <= {3'h0, 1'b1, 4'h0, 1'b0, 2'h0};
    end
    else
    begin
      live <= ok ? live : live + 2'h1;
      sh_cfg <= (wr && idx == `CTC_IDX_PIN_CFG) ? pwdata[2:0] : sh_cfg;
      sh_soft <= (wr && idx == `CTC_IDX_SOFT_TRIG) ? pwdata[0] : sh_soft;
      sh_en <= (wr && idx == `CTC_IDX_IRQ_ENABLE) ? pwdata[3:0] : sh_en;
      sh_bg <= (wr && idx == `CTC_IDX_BG_CTRL) ? pwdata[0] : sh_bg;
    end
  end

  // ============================================================
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_STAT_FG: assert property (ok && $past(sh_cfg[2:1]) == 2'h0 |-> calibration_status_pin == $past(foreground_done_flag))
    else $error("stat fg");
  AST_STAT_STOP: assert property (ok && $past(sh_cfg[2:1]) == 2'h1 |-> calibration_status_pin == $past(calibration_stopped_flag))
    else $error("stat stop");
  AST_STAT_ALARM: assert property (ok && $past(sh_cfg[2:1]) == 2'h2 |-> calibration_status_pin == $past(alarm_flag))
    else $error("stat alarm");
  AST_STAT_LOW: assert property (ok && $past(sh_cfg[2:1]) == 2'h3 |-> !calibration_status_pin)
    else $error("stat low");
  AST_TRIG_SOFT: assert property (ok && !$past(sh_cfg[0]) |-> calibration_trigger == $past(sh_soft))
    else $error("trig soft");
  AST_TRIG_PIN: assert property (ok && $past(sh_cfg[0]) |-> calibration_trigger == $past(calibration_trigger_pin))
    else $error("trig pin");
  AST_ONE_WAIT: assert property (ok |-> pready == $past(psel && !penable))
    else $error("pready late");
  AST_SLVERR: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr");
  AST_RD_PIN: assert property (pready && !pwrite && paddr == {`CTC_IDX_PIN_CFG, 2'h0} |-> prdata == {29'h0, sh_cfg})
    else $error("pin cfg read");
  AST_IRQ_MASK: assert property (ok && sh_en == 4'h0 && $past(sh_en) == 4'h0 |-> !irq)
    else $error("irq masked");
  AST_LP_IDLE: assert property (ok && !sh_bg && !$past(sh_bg) && !$past(sh_bg, 2) && !$past(sh_bg, 3)
    |-> !adc_sleep && !cal_request)
    else $error("lp active");

  COV_IRQ: cover property (irq);
  COV_CAL: cover property (ok && $rose(cal_request));
  COV_ERR: cover property (pready && pslverr);
endmodule

bind ctc_top ctc_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .foreground_done_flag(foreground_done_flag),
  .calibration_stopped_flag(calibration_stopped_flag), .alarm_flag(alarm_flag),
  .calibration_trigger(calibration_trigger), .adc_sleep(adc_sleep), .cal_request(cal_request),
  .calibration_status_pin(calibration_status_pin), .calibration_trigger_pin(calibration_trigger_pin), .irq(irq));
`default_nettype wire

// *** tb/ctc_top_test.sv ***
// Self-checking bench for the calibration trigger control block.
// Assumes short sleep and wake tables.
`timescale 1ns/1ps
`default_nettype none
`include "ctc_consts.vh"

module ctc_top_test;
  localparam logic [11:0] A_PIN = {`CTC_IDX_PIN_CFG, 2'h0}, A_SOFT = {`CTC_IDX_SOFT_TRIG, 2'h0},
    A_LP = {`CTC_IDX_LP_CFG, 2'h0}, A_BG = {`CTC_IDX_BG_CTRL, 2'h0}, A_IST = {`CTC_IDX_IRQ_STATUS, 2'h0},
    A_IEN = {`CTC_IDX_IRQ_ENABLE, 2'h0}, A_ICLR = {`CTC_IDX_IRQ_CLEAR, 2'h0};
  logic        pclk, presetn, psel, penable, pwrite, trig_cmd, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [2:0]  flag_cmd;
  int          err_count, checked, cycles;
  wire  [31:0] prdata;
  wire         pready, pslverr, fg, stp, alm, step_done, trig, adc_sleep, cal_request, pin, stat, irq;

  ctc_top #(
    .SLEEP_CYCLES({41'd36, 41'd32, 41'd28, 41'd24, 41'd20, 41'd16, 41'd12, 41'd8}),
    .WAKE_CYCLES ({41'd9, 41'd7, 41'd5, 41'd3})
  ) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .foreground_done_flag(fg), .calibration_stopped_flag(stp), .alarm_flag(alm),
    .cal_cycle_done(step_done), .calibration_trigger(trig), .adc_sleep(adc_sleep),
    .cal_request(cal_request), .calibration_trigger_pin(pin), .calibration_status_pin(stat), .irq(irq));

  ctc_engine_model #(.STEP_WAIT(4)) u_model (.pclk(pclk), .presetn(presetn), .flag_cmd(flag_cmd),
    .trig_cmd(trig_cmd), .cal_request(cal_request), .foreground_done_flag(fg),
    .calibration_stopped_flag(stp), .alarm_flag(alm), .cal_cycle_done(step_done),
    .calibration_trigger_pin(pin));

  // ============================================================
  // Shared tasks
  task automatic complete_run;
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    cmp_bit(pready, 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask

  task automatic wait_req(input logic lvl, output int n);
    n = 0;
    while (cal_request !== lvl && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
    cmp_bit(cal_request, lvl);
  endtask

  // ============================================================
  // Scenarios
  task automatic t_reset;
    xfer(A_PIN, 0, 0); cmp_word(rd, 32'h00);
    xfer(A_SOFT, 0, 0); cmp_word(rd, 32'h01);
    xfer(A_LP, 0, 0); cmp_word(rd, 32'h88);
    cmp_bit(trig, 1'b1);
  endtask

  task automatic t_status;
    logic [2:0] pat;
    for (int s = 0; s < 8; s++)
    begin
      xfer(A_PIN, 1, {29'h0, s[2:1], 1'b0});
      pat = s[0] ? 3'h1 << s[2:1] : ~(3'h1 << s[2:1]);
      flag_cmd <= pat;
      wait_cyc(3);
      cmp_bit(stat, s[2:1] == 2'h3 ? 1'b0 : s[0]);
    end
  endtask

  task automatic t_trigger;
    for (int i = 0; i < 4; i++)
    begin
      xfer(A_PIN, 1, {31'h0, i[1]});
      xfer(A_SOFT, 1, {31'h0, i[0]});
      trig_cmd <= ~i[0];
      wait_cyc(3);
      cmp_bit(trig, i[1] ? ~i[0] : i[0]);
    end
    xfer(A_PIN, 1, 0);
  endtask

  task automatic t_errors;
    xfer(12'h1B4, 1, 32'hFF); cmp_bit(er, 1'b1);
    xfer(12'h1AD, 0, 0); cmp_bit(er, 1'b1);
    cmp_word(rd, 32'h0);
    xfer(A_PIN, 0, 0); cmp_bit(er, 1'b0);
    cmp_word(rd, 32'h0);
  endtask

  task automatic t_irq;
    flag_cmd <= 3'h0;
    xfer(A_ICLR, 1, 32'hF);
    flag_cmd <= 3'h1;
    wait_cyc(4);
    cmp_bit(irq, 1'b0);
    xfer(A_IST, 0, 0); cmp_word(rd, 32'h1);
    xfer(A_IEN, 1, 1); wait_cyc(2); cmp_bit(irq, 1'b1);
    xfer(A_ICLR, 1, 1); wait_cyc(2); cmp_bit(irq, 1'b0);
    xfer(A_IST, 0, 0); cmp_word(rd, 32'h0);
    xfer(A_IEN, 1, 0);
  endtask

  task automatic t_low_power;
    int n;
    xfer(A_LP, 1, 32'h89); wait_cyc(8); cmp_bit(adc_sleep, 1'b0);
    trig_cmd <= 1'b1;
    xfer(A_PIN, 1, 1);
    xfer(A_LP, 1, 32'h8B);
    xfer(A_BG, 1, 1);
    wait_cyc(60);
    cmp_bit(adc_sleep, 1'b1); cmp_bit(cal_request, 1'b0);
    trig_cmd <= 1'b0;
    wait_req(1'b1, n);
    trig_cmd <= 1'b1;
    xfer(A_LP, 1, 32'h89);
    wait_req(1'b0, n);
    wait_req(1'b1, n);
    cmp_bit(n >= 26 && n <= 34, 1'b1);
    xfer(A_BG, 1, 0); wait_cyc(4);
    cmp_bit(adc_sleep, 1'b0); cmp_bit(cal_request, 1'b0);
    xfer(A_PIN, 1, 0);
  endtask

  // ============================================================
  // Clock, reset, timeout and main sequence
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      err_count++;
      complete_run();
    end
  end

  initial
  begin
    {presetn, psel, penable, pwrite, trig_cmd, er} = 6'h0;
    {paddr, pwdata, rd, flag_cmd} = '0;
    {err_count, checked, cycles} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_status();
    t_trigger();
    t_errors();
    t_irq();
    t_low_power();
    complete_run();
  end
endmodule
`default_nettype wire
